// [fxu_pkg.sv]
/*
 * Shared constants for the negate/logic execution slice: instruction field
 * positions, opcodes, flag positions and the register map of the slave.
 * Assumes 32-bit instruction words with architectural bit 0 as the msb.
 */
package fxu_pkg;

	localparam int data_width = 32;
	localparam int addr_width = 8;

	typedef enum logic [1:0]
	{
		op_none = 2'b00,
		op_nabs = 2'b01,
		op_nand = 2'b10,
		op_neg = 2'b11
	} op_type;

	// ----------------------------------------------------------------
	// instruction fields (architectural bit 0 is word bit 31)
	// ----------------------------------------------------------------
	localparam int primary_hi = 31;
	localparam int primary_lo = 26;
	localparam int first_field_hi = 25;
	localparam int first_field_lo = 21;
	localparam int reg_a_hi = 20;
	localparam int reg_a_lo = 16;
	localparam int reg_b_hi = 15;
	localparam int reg_b_lo = 11;
	localparam int overflow_enable_pos = 10;
	localparam int xo9_hi = 9;
	localparam int xo10_hi = 10;
	localparam int xo_lo = 1;
	localparam int record_pos = 0;

	localparam logic [5:0] primary_opcode = 6'h1f;
	localparam logic [8:0] xo_nabs = 9'h1e8;
	localparam logic [8:0] xo_neg = 9'h068;
	localparam logic [9:0] xo_nand = 10'h1dc;
	localparam logic [31:0] most_negative = 32'h8000_0000;

	// ----------------------------------------------------------------
	// flag positions
	// ----------------------------------------------------------------
	localparam int summary_overflow_pos = 31;
	localparam int overflow_flag_pos = 30;
	localparam int carry_flag_pos = 29;
	localparam int less_than_pos = 3;
	localparam int greater_than_pos = 2;
	localparam int equal_pos = 1;
	localparam int field_summary_pos = 0;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ctrl_offset = 8'h00;
	localparam logic [7:0] exception_offset = 8'h04;
	localparam logic [7:0] condition_offset = 8'h08;
	localparam logic [7:0] result_offset = 8'h0c;
	localparam logic [7:0] status_offset = 8'h10;
	localparam logic [7:0] mask_offset = 8'h14;
	localparam int legacy_pos = 0;
	localparam int event_count = 3;
	localparam int ev_done = 0;
	localparam int ev_overflow = 1;
	localparam int ev_illegal = 2;
	localparam logic [31:0] ctrl_reset = 32'h0000_0001;
	localparam logic [31:0] exception_flag_mask = 32'he000_0000;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;

endpackage

// [exec_if.sv]
/*
 * Carrier between the execution top and its decoder and condition helpers.
 * Assumes all three sit on the same clock.
 */
`timescale 1ns/1ns
interface exec_if;
	import fxu_pkg::*;

	logic [31:0] instr;
	logic legacy_enable;
	fxu_pkg::op_type op;
	logic [4:0] write_index;
	logic overflow_enable;
	logic record_bit;
	logic [31:0] result;
	logic so_in;
	logic [3:0] cr;

	modport decode_side
	(
		input instr,
		input legacy_enable,
		output op,
		output write_index,
		output overflow_enable,
		output record_bit
	);
	modport calc_side
	(
		input result,
		input so_in,
		output cr
	);
	modport core
	(
		output instr,
		output legacy_enable,
		input op,
		input write_index,
		input overflow_enable,
		input record_bit,
		output result,
		output so_in,
		input cr
	);
endinterface

// [op_decode.sv]
/*
 * Instruction decoder: recognises the three operations and picks the
 * destination field. Assumes a stable instruction word from the core.
 */
`timescale 1ns/1ns
module op_decode
(
	exec_if.decode_side bus
);
	import fxu_pkg::*;

	wire primary_hit = bus.instr[primary_hi:primary_lo] == primary_opcode;
	wire [8:0] xo9 = bus.instr[xo9_hi:xo_lo];
	wire [9:0] xo10 = bus.instr[xo10_hi:xo_lo];
	wire hit_nabs = primary_hit && xo9 == xo_nabs && bus.legacy_enable; // [RULE1] [RULE2]
	wire hit_neg = primary_hit && xo9 == xo_neg; // [RULE9]
	wire hit_nand = primary_hit && xo10 == xo_nand; // [RULE7] [RULE8]
	wire [4:0] target_register_field = bus.instr[first_field_hi:first_field_lo]; // [RULE13]
	wire [4:0] register_a_field = bus.instr[reg_a_hi:reg_a_lo]; // [RULE13]

	assign bus.op = hit_nand ? op_nand : hit_neg ? op_neg : hit_nabs ? op_nabs : op_none;
	// nand writes the register a field, the single-operand forms the first field
	assign bus.write_index = hit_nand ? register_a_field : target_register_field;
	// nand has no overflow-enable bit: bit 21 is part of its opcode
	assign bus.overflow_enable = !hit_nand && bus.instr[overflow_enable_pos]; // [RULE8]
	assign bus.record_bit = bus.instr[record_pos];
endmodule

// [condition_calc.sv]
/*
 * Condition field builder: signed compare of a result against zero plus
 * the summary overflow copy. Purely combinational.
 */
`timescale 1ns/1ns
module condition_calc
(
	exec_if.calc_side bus
);
	import fxu_pkg::*;

	wire is_zero = bus.result == 32'h0000_0000;
	wire is_neg = bus.result[31];

	assign bus.cr[less_than_pos] = is_neg; // [RULE5] [RULE14]
	assign bus.cr[greater_than_pos] = !is_neg && !is_zero; // [RULE5] [RULE14]
	assign bus.cr[equal_pos] = is_zero; // [RULE5] [RULE14]
	assign bus.cr[field_summary_pos] = bus.so_in; // [RULE12] [RULE14]
endmodule

// [fxu_negate_logic.sv]
/*
 * Fixed-point slice for negative-absolute, complemented-and and negate,
 * with an AXI4-Lite register slave and a level interrupt.
 * Assumes the issue logic and register file sit on aclk; operands are
 * presented with issue_valid in the same cycle.
 */
// Operation
// [RULE1] nabs (31/488) writes minus the absolute value of register a to target.
// [RULE2] nabs is recognised only while legacy instruction set is enabled.
// [RULE3] nabs with overflow enable clears overflow, keeps summary overflow.
// [RULE4] nabs never alters the carry flag.
// [RULE5] record bit set: lt, gt, eq from signed result, summary overflow updated.
// [RULE6] exception register only on overflow enable, condition field only on record.
// [RULE7] nand (31/476) writes not(source and register b) to register a.
// [RULE8] nand has no overflow enable; exception register untouched.
// [RULE9] neg (31/104) writes ones' complement of register a plus one.
// [RULE10] neg of 0x80000000 returns it and flags overflow when enabled.
// [RULE11] neg with overflow enable updates overflow and summary; carry never.
// [RULE12] recorded forms copy summary overflow from exception register.
// [RULE13] fields: opcode 0-5, target/source 6-10, a 11-15, b 16-20.
// [RULE14] condition field order lt, gt, eq, summary overflow from msb.
`timescale 1ns/1ns
module fxu_negate_logic
#(
	parameter int addr_bits = fxu_pkg::addr_width
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [addr_bits-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [addr_bits-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic issue_valid,
	input wire logic [31:0] issue_instr,
	input wire logic [31:0] source_register_value,
	input wire logic [31:0] register_a_value,
	input wire logic [31:0] register_b_value,
	output logic wb_valid,
	output logic [4:0] wb_index,
	output logic [31:0] wb_data,
	output logic [31:0] exception_register_value,
	output logic [3:0] condition_field_value,
	output logic irq
);
	import fxu_pkg::*;

	// elaboration check: the offsets reach up to the mask register
	// a wider bus is cut to eight offset bits in the decoders below
	if (addr_bits < 5)
	begin
		$error("addr_bits too small for the register map");
	end

	exec_if ex ();

	op_decode decoder
	(
		.bus(ex.decode_side)
	);

	condition_calc cond
	(
		.bus(ex.calc_side)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0] ctrl;
	logic [31:0] fixed_point_exception_register;
	logic [3:0] condition_field_zero;
	logic [31:0] last_result;
	logic [event_count-1:0] status;
	logic [event_count-1:0] mask;
	logic aw_full;
	logic w_full;
	logic [addr_bits-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// ----------------------------------------------------------------
	// execution
	// ----------------------------------------------------------------
	assign ex.instr = issue_instr;
	assign ex.legacy_enable = ctrl[legacy_pos]; // [RULE2]

	wire [31:0] negated = ~register_a_value + 32'h0000_0001; // [RULE9]
	wire [31:0] nabs_value = register_a_value[31] ? register_a_value : negated; // [RULE1]
	wire [31:0] nand_value = ~(source_register_value & register_b_value); // [RULE7]
	wire neg_overflow = register_a_value == most_negative; // [RULE10]

	assign ex.result = ex.op == op_nand ? nand_value :
		ex.op == op_nabs ? nabs_value : negated;

	wire legal = ex.op != op_none;
	wire take = issue_valid && legal;
	wire oe_update = take && ex.overflow_enable && ex.op != op_nand; // [RULE6] [RULE8]
	wire rc_update = take && ex.record_bit; // [RULE6]
	wire new_overflow = ex.op == op_neg ? neg_overflow : 1'b0; // [RULE3] [RULE10] [RULE11]
	wire old_so = fixed_point_exception_register[summary_overflow_pos];
	// nabs leaves summary overflow, neg accumulates it
	wire new_so = ex.op == op_neg ? (old_so | neg_overflow) : old_so; // [RULE3] [RULE11]

	logic [31:0] issued_exception;
	always_comb
	begin
		issued_exception = fixed_point_exception_register;
		issued_exception[overflow_flag_pos] = new_overflow;
		issued_exception[summary_overflow_pos] = new_so;
	end

	// condition field sees the summary overflow as it stands after this op
	assign ex.so_in = oe_update ? new_so : old_so; // [RULE12]

	// ----------------------------------------------------------------
	// bus write path
	// ----------------------------------------------------------------
	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire do_write = aw_full && w_full && !s_axi_bvalid;
	wire next_aw_full = aw_hs || (aw_full && !do_write);
	wire next_w_full = w_hs || (w_full && !do_write);
	wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
	wire [7:0] w_offset = 8'(aw_addr);
	wire [31:0] byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire wr_ctrl = do_write && w_offset == ctrl_offset;
	wire wr_exception = do_write && w_offset == exception_offset;
	wire wr_status = do_write && w_offset == status_offset;
	wire wr_mask = do_write && w_offset == mask_offset;
	wire wr_known = w_offset == ctrl_offset || w_offset == exception_offset ||
		w_offset == condition_offset || w_offset == result_offset ||
		w_offset == status_offset || w_offset == mask_offset;
	wire [31:0] ctrl_merge = (ctrl & ~byte_mask) | (w_data & byte_mask);
	wire [31:0] exception_merge = (fixed_point_exception_register & ~byte_mask) |
		(w_data & byte_mask & exception_flag_mask);
	wire [31:0] mask_merge = ({29'h0, mask} & ~byte_mask) | (w_data & byte_mask);
	wire [event_count-1:0] clear_bits = wr_status ?
		w_data[event_count-1:0] & byte_mask[event_count-1:0] : '0;

	// ----------------------------------------------------------------
	// bus read path
	// ----------------------------------------------------------------
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	wire next_rvalid = ar_hs || (s_axi_rvalid && !s_axi_rready);
	wire [7:0] r_offset = 8'(s_axi_araddr);
	logic [31:0] read_word;
	logic read_known;
	always_comb
	begin
		read_word = 32'h0000_0000;
		read_known = 1'b1;
		if (r_offset == ctrl_offset)
		begin
			read_word = ctrl;
		end
		else if (r_offset == exception_offset)
		begin
			read_word = fixed_point_exception_register;
		end
		else if (r_offset == condition_offset)
		begin
			read_word = {28'h0, condition_field_zero};
		end
		else if (r_offset == result_offset)
		begin
			read_word = last_result;
		end
		else if (r_offset == status_offset)
		begin
			read_word = {29'h0, status};
		end
		else if (r_offset == mask_offset)
		begin
			read_word = {29'h0, mask};
		end
		else
		begin
			read_known = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// events
	// ----------------------------------------------------------------
	logic [event_count-1:0] events;
	always_comb
	begin
		events = '0;
		events[ev_done] = take;
		events[ev_overflow] = oe_update && new_overflow;
		events[ev_illegal] = issue_valid && !legal;
	end
	// a new event beats a clear in the same cycle
	wire [event_count-1:0] next_status = (status & ~clear_bits) | events;

	// ----------------------------------------------------------------
	// bus handshake flops
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= resp_okay;
		end
		else
		begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			s_axi_awready <= !next_aw_full;
			s_axi_wready <= !next_w_full;
			s_axi_bvalid <= next_bvalid;
			if (do_write)
			begin
				s_axi_bresp <= wr_known ? resp_okay : resp_slverr;
			end
			s_axi_arready <= !next_rvalid;
			s_axi_rvalid <= next_rvalid;
			if (ar_hs)
			begin
				s_axi_rdata <= read_word;
				s_axi_rresp <= read_known ? resp_okay : resp_slverr;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_addr <= '0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end
		else
		begin
			if (aw_hs)
			begin
				aw_addr <= s_axi_awaddr;
			end
			if (w_hs)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// ----------------------------------------------------------------
	// control and interrupt registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= ctrl_reset;
			mask <= '0;
			status <= '0;
			irq <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				ctrl <= ctrl_merge & ctrl_reset;
			end
			if (wr_mask)
			begin
				mask <= mask_merge[event_count-1:0];
			end
			status <= next_status;
			irq <= |(next_status & (wr_mask ? mask_merge[event_count-1:0] : mask));
		end
	end

	// ----------------------------------------------------------------
	// architectural flags and writeback
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fixed_point_exception_register <= 32'h0000_0000;
			condition_field_zero <= 4'h0;
			last_result <= 32'h0000_0000;
		end
		else
		begin
			// an executing instruction takes priority over a software write
			if (oe_update)
			begin
				fixed_point_exception_register <= issued_exception; // [RULE3] [RULE4] [RULE11]
			end
			else if (wr_exception)
			begin
				fixed_point_exception_register <= exception_merge;
			end
			if (rc_update)
			begin
				condition_field_zero <= ex.cr; // [RULE5] [RULE12]
			end
			if (take)
			begin
				last_result <= ex.result;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wb_valid <= 1'b0;
			wb_index <= 5'h00;
			wb_data <= 32'h0000_0000;
		end
		else
		begin
			wb_valid <= take;
			if (take)
			begin
				wb_index <= ex.write_index; // [RULE7] [RULE13]
				wb_data <= ex.result; // [RULE1] [RULE9] [RULE10]
			end
		end
	end

	assign exception_register_value = fixed_point_exception_register;
	assign condition_field_value = condition_field_zero;

endmodule

// [fxu_negate_logic_sva.sv]
/* checker for the issue port of the negate/logic slice.
   bound into fxu_negate_logic; sees only its ports. */
`timescale 1ns/1ns
module fxu_negate_logic_sva
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic issue_valid,
	input wire logic [31:0] issue_instr,
	input wire logic [31:0] source_register_value,
	input wire logic [31:0] register_a_value,
	input wire logic [31:0] register_b_value,
	input wire logic wb_valid,
	input wire logic [4:0] wb_index,
	input wire logic [31:0] wb_data,
	input wire logic [31:0] exception_register_value,
	input wire logic [3:0] condition_field_value
);
	import fxu_pkg::*;
	wire logic ours = issue_valid && issue_instr[31:26] == primary_opcode;
	wire logic is_nabs = ours && issue_instr[9:1] == xo_nabs;
	wire logic is_neg = ours && issue_instr[9:1] == xo_neg;
	wire logic is_nand = ours && issue_instr[10:1] == xo_nand;
	wire logic known = is_nabs || is_neg || is_nand;
	wire logic oe = issue_instr[overflow_enable_pos];
	wire logic [31:0] nabs_exp = register_a_value[31] ? register_a_value : 32'h0 - register_a_value;
	wire logic [31:0] neg_exp = ~register_a_value + 32'h1;
	wire logic [31:0] nand_exp = ~(source_register_value & register_b_value);
	wire logic [2:0] sign_bits = {wb_data[31], !wb_data[31] && |wb_data, ~|wb_data};
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_neg_ovf;
		is_neg && oe && register_a_value == most_negative;
	endsequence
	sequence s_recorded;
		known && issue_instr[record_pos] ##1 wb_valid;
	endsequence
	a_wb_cause: assert property (wb_valid |-> $past(known))
		else $error("writeback without a recognised issue");
	a_nabs_value: assert property (is_nabs |=> !wb_valid
		|| wb_data == $past(nabs_exp) && wb_index == $past(issue_instr[25:21]))
		else $error("negative absolute result wrong");
	a_neg_value: assert property (is_neg |=>
		wb_valid && wb_data == $past(neg_exp))
		else $error("negation result wrong");
	a_nand_value: assert property (is_nand |=> wb_valid
		&& wb_data == $past(nand_exp) && wb_index == $past(issue_instr[20:16]))
		else $error("complemented and result wrong");
	a_nand_exception: assert property (is_nand |=>
		$stable(exception_register_value))
		else $error("complemented and touched exception register");
	a_carry_kept: assert property (issue_valid |=>
		$stable(exception_register_value[carry_flag_pos]))
		else $error("carry changed by an instruction");
	a_nabs_overflow: assert property (is_nabs && oe |=> !wb_valid
		|| !exception_register_value[overflow_flag_pos]
		&& $stable(exception_register_value[summary_overflow_pos]))
		else $error("negative absolute overflow handling wrong");
	a_neg_ovf: assert property (s_neg_ovf |=>
		exception_register_value[summary_overflow_pos]
		&& exception_register_value[overflow_flag_pos])
		else $error("negation overflow not flagged");
	a_no_oe_exception: assert property ((is_nabs || is_neg) && !oe |=>
		$stable(exception_register_value))
		else $error("exception register changed without overflow enable");
	a_plain_form: assert property (issue_valid && !issue_instr[record_pos] |=>
		$stable(condition_field_value))
		else $error("condition field changed without record");
	a_condition_bits: assert property (s_recorded |->
		condition_field_value == {sign_bits, exception_register_value[summary_overflow_pos]})
		else $error("condition field wrong");
endmodule
bind fxu_negate_logic fxu_negate_logic_sva chk (.*);

// [issue_model.sv]
/* model of the issue logic and register file facing the slice.
   assumes each call starts just after a rising edge of aclk. */
`timescale 1ns/1ns
module issue_model
(
	input wire logic aclk,
	output logic issue_valid,
	output logic [31:0] issue_instr,
	output logic [31:0] source_register_value,
	output logic [31:0] register_a_value,
	output logic [31:0] register_b_value,
	input wire logic wb_valid,
	input wire logic [4:0] wb_index,
	input wire logic [31:0] wb_data
);
	logic [31:0] register_file [32];
	initial
	begin
		issue_valid = 1'b0;
		issue_instr = 32'h0;
		source_register_value = 32'h0;
		register_a_value = 32'h0;
		register_b_value = 32'h0;
		foreach (register_file[i])
			register_file[i] = 32'h0;
	end
	always @(posedge aclk)
		if (wb_valid)
			register_file[wb_index] <= wb_data;
	task automatic issue(input logic [31:0] w);
		issue_valid <= 1'b1;
		issue_instr <= w;
		source_register_value <= register_file[w[25:21]];
		register_a_value <= register_file[w[20:16]];
		register_b_value <= register_file[w[15:11]];
		@(posedge aclk);
	endtask
	// idle operands flip so a stale value is never taken for a live one
	task automatic idle();
		issue_valid <= 1'b0;
		source_register_value <= ~source_register_value;
		register_a_value <= ~register_a_value;
		register_b_value <= ~register_b_value;
		@(posedge aclk);
	endtask
endmodule

// [fxu_negate_logic_tb_top.sv]
/* self-checking bench: axi4-lite master tasks, issue model, scenarios.
   assumes fxu_pkg, the design, checker and issue model compile first. */
`timescale 1ns/1ns
module fxu_negate_logic_tb_top;
	import fxu_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic issue_valid, wb_valid, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [3:0] s_axi_wstrb, condition_field_value;
	logic [1:0] s_axi_bresp, s_axi_rresp, bresp_seen;
	logic [4:0] wb_index;
	logic [31:0] s_axi_wdata, s_axi_rdata, issue_instr, source_register_value, register_a_value;
	logic [31:0] register_b_value, wb_data, exception_register_value;
	int err_count, comparisons;
	fxu_negate_logic dut (.*);
	issue_model m (.*);
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// ------------------------------------------------------------
	// bus and check helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w)
		begin
			@(posedge aclk);
			if (aw && s_axi_awready)
			begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready)
			begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		bresp_seen = s_axi_bresp;
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		chk(s_axi_rdata, e);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	function automatic logic [31:0] enc(input logic [9:0] x, input logic [4:0] f1, f2, f3,
		input logic record);
		return {primary_opcode, f1, f2, f3, x, record};
	endfunction
	task automatic run(input logic [31:0] w, input logic [31:0] e, xe, input logic [3:0] ce);
		m.issue(w);
		m.idle();
		#1;
		chk(m.register_file[w[25:21]], e);
		chk(exception_register_value, xe);
		chk({28'h0, condition_field_value}, {28'h0, ce});
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_reset();
		axr(ctrl_offset, ctrl_reset, resp_okay);
		axr(exception_offset, 32'h0, resp_okay);
		axr(condition_offset, 32'h0, resp_okay);
		axr(result_offset, 32'h0, resp_okay);
		axr(mask_offset, 32'h0, resp_okay);
		axr(status_offset, 32'h0, resp_okay);
		axr(8'h18, 32'h0, resp_slverr);
		axw(8'h18, 32'hffff_ffff);
		chk({30'h0, bresp_seen}, {30'h0, resp_slverr});
		$display("test reset finished");
	endtask
	task automatic test_nabs();
		axw(exception_offset, 32'he000_0000);
		run(enc({1'b0, xo_nabs}, 5'h06, 5'h04, 5'h00, 1'b0), 32'hffff_d000, 32'he000_0000, 4'h0);
		run(enc({1'b1, xo_nabs}, 5'h0b, 5'h04, 5'h00, 1'b1), 32'hffff_d000, 32'ha000_0000, 4'h9);
		run(enc({1'b0, xo_nabs}, 5'h0c, 5'h0a, 5'h00, 1'b1), 32'h0, 32'ha000_0000, 4'h3);
		run(enc({1'b1, xo_nabs}, 5'h0d, 5'h07, 5'h1f, 1'b0), 32'h8000_0000, 32'ha000_0000, 4'h3);
		$display("test negative absolute finished");
	endtask
	task automatic test_neg();
		axw(exception_offset, 32'h2000_0000);
		run(enc({1'b0, xo_neg}, 5'h0e, 5'h09, 5'h00, 1'b1), 32'h6fff_d000, 32'h2000_0000, 4'h4);
		run(enc({1'b1, xo_neg}, 5'h0f, 5'h08, 5'h00, 1'b0), 32'h8765_8765, 32'h2000_0000, 4'h4);
		run(enc({1'b1, xo_neg}, 5'h10, 5'h07, 5'h00, 1'b1), 32'h8000_0000, 32'he000_0000, 4'h9);
		run(enc({1'b1, xo_neg}, 5'h11, 5'h09, 5'h00, 1'b1), 32'h6fff_d000, 32'ha000_0000, 4'h5);
		axr(status_offset, 32'h3, resp_okay);
		axw(status_offset, 32'h3);
		axr(status_offset, 32'h0, resp_okay);
		$display("test negate finished");
	endtask
	task automatic test_nand();
		m.issue(enc(xo_nand, 5'h09, 5'h12, 5'h08, 1'b1));
		m.issue(enc(xo_nand, 5'h04, 5'h13, 5'h05, 1'b0));
		m.idle();
		@(posedge aclk);
		#1;
		chk(m.register_file[18], 32'hefff_cfff);
		chk(m.register_file[19], 32'hffff_cfff);
		chk(exception_register_value, 32'ha000_0000);
		chk({28'h0, condition_field_value}, 32'h9);
		$display("test complemented and finished");
	endtask
	task automatic test_legacy();
		axw(ctrl_offset, 32'h0);
		axw(mask_offset, 32'h4);
		m.issue(enc({1'b0, xo_nabs}, 5'h14, 5'h04, 5'h00, 1'b0));
		m.idle();
		#1;
		chk(m.register_file[20], 32'h0);
		chk({31'h0, irq}, 32'h1);
		axr(status_offset, 32'h5, resp_okay);
		axw(status_offset, 32'h5);
		#1;
		chk({31'h0, irq}, 32'h0);
		axw(ctrl_offset, 32'h1);
		run(enc({1'b0, xo_nabs}, 5'h14, 5'h04, 5'h00, 1'b0), 32'hffff_d000, 32'ha000_0000, 4'h9);
		axr(condition_offset, 32'h9, resp_okay);
		axr(result_offset, 32'hffff_d000, resp_okay);
		$display("test legacy set finished");
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
		{s_axi_awprot, s_axi_arprot, s_axi_awaddr, s_axi_araddr} = 22'h0;
		s_axi_wdata = 32'h0;
		err_count = 0;
		comparisons = 0;
		repeat (12) @(posedge aclk);
		// loaded after time zero so the model's own clearing cannot overwrite them
		m.register_file[4] = 32'h0000_3000;
		m.register_file[5] = 32'hffff_ffff;
		m.register_file[7] = 32'h8000_0000;
		m.register_file[8] = 32'h789a_789b;
		m.register_file[9] = 32'h9000_3000;
		aresetn <= 1'b1;
		@(posedge aclk);
		test_reset();
		test_nabs();
		test_neg();
		test_nand();
		test_legacy();
		final_report();
	end
	initial
	begin
		repeat (5000) @(posedge aclk);
		err_count++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		final_report();
	end
endmodule
